// File: hdl/tcc_consts.vh
// Constants for the thermistor charge configuration register bank.
// Assumes inclusion by bare name from the design files under hdl/.
`ifndef TCC_CONSTS_VH
`define TCC_CONSTS_VH

// Register offsets
`define TCC_OFS_REDUCTION    8'h61
`define TCC_OFS_COLD         8'h62
`define TCC_OFS_COOL         8'h63
`define TCC_OFS_WARM         8'h64
`define TCC_OFS_HOT          8'h65
`define TCC_OFS_PART_ID      8'h6f

// Reset values
`define TCC_RST_REDUCTION    8'h34
`define TCC_RST_COLD         8'h7c
`define TCC_RST_COOL         8'h6d
`define TCC_RST_WARM         8'h38
`define TCC_RST_HOT          8'h27

// Part code, value is arbitrary
`define TCC_PART_CODE        8'h5a

// Bus target address (7 bit), value is arbitrary
`define TCC_BUS_ADDR         7'h55

// Field positions in the reduction register
`define TCC_VCUT_MSB         6
`define TCC_VCUT_LSB         4
`define TCC_ISCALE_MSB       2
`define TCC_ISCALE_LSB       0

// Scaling
`define TCC_VCUT_STEP_MV     9'h032
`define TCC_ISCALE_FULL      4'h8

// Zone codes
`define TCC_ZONE_NORMAL      3'h0
`define TCC_ZONE_COLD        3'h1
`define TCC_ZONE_COOL        3'h2
`define TCC_ZONE_WARM        3'h3
`define TCC_ZONE_HOT         3'h4

// Bits per byte on the bus, counted 0..8 on received bytes and 1..8 on sent bytes
`define TCC_BYTE_BITS        4'h8

`endif

// File: hdl/tcc_bus_edge.v
// Bus line edge and frame condition detector.
// Assumes scl and sda are already synchronous to clk.
`timescale 1ns/100ps
`include "tcc_consts.vh"

module tcc_bus_edge (
   // Clock and reset
   input  wire clk,
   input  wire rst_b,
   // Bus lines as seen on the pins
   input  wire scl,
   input  wire sda,
   // Detected events, one cycle each
   output wire scl_rise,
   output wire scl_fall,
   output wire start_det,
   output wire stop_det
);

   reg         scl_q;
   reg         sda_q;

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
      end
   end

   assign scl_rise  = scl & ~scl_q;
   assign scl_fall  = ~scl & scl_q;
   // Data changes while the clock line stays high mark frame boundaries
   assign start_det = scl & scl_q & sda_q & ~sda;
   assign stop_det  = scl & scl_q & ~sda_q & sda;

endmodule

// File: hdl/tcc_zone.v
// Temperature zone classifier and reduction selector.
// Assumes the sense code uses the same weighting as the limit registers
// and that a higher sense voltage means a colder battery.
`timescale 1ns/100ps
`include "tcc_consts.vh"

module tcc_zone (
   // Sense input and limits
   input  wire [7:0] sense_code,
   input  wire [7:0] cold_threshold,
   input  wire [7:0] cool_threshold,
   input  wire [7:0] warm_threshold,
   input  wire [7:0] hot_threshold,
   // Configured reductions
   input  wire [2:0] warm_voltage_cut,
   input  wire [2:0] temp_current_scale,
   // Results
   output reg  [2:0] zone,
   output reg  [2:0] vcut_code,
   output reg  [2:0] iscale_code,
   output reg        charge_hold
);

   always @* begin
      zone        = `TCC_ZONE_NORMAL;
      vcut_code   = 3'h0;
      iscale_code = 3'h0;
      charge_hold = 1'b0;
      if (sense_code >= cold_threshold) begin
         zone        = `TCC_ZONE_COLD;
         charge_hold = 1'b1;
      end else if (sense_code <= hot_threshold) begin
         zone        = `TCC_ZONE_HOT;
         charge_hold = 1'b1;
      end else if (sense_code >= cool_threshold) begin
         zone        = `TCC_ZONE_COOL;
         iscale_code = temp_current_scale;
      end else if (sense_code <= warm_threshold) begin
         zone        = `TCC_ZONE_WARM;
         vcut_code   = warm_voltage_cut;
         iscale_code = temp_current_scale;
      end
   end

endmodule

// File: hdl/tcc_regs.v
// Thermistor charge configuration register bank behind a two-wire target port.
// Assumes scl and sda_in are synchronous to clk and the bus runs far slower
// than clk; the target never stretches the clock.
`timescale 1ns/100ps
`include "tcc_consts.vh"

module tcc_regs (
   // Clock and reset
   input  wire       clk,
   input  wire       rst_b,
   // Two-wire bus, open drain data
   input  wire       scl,
   input  wire       sda_in,
   output reg        sda_out,
   output reg        sda_oe,
   // Digitised thermistor sense voltage
   input  wire [7:0] sense_code,
   // Limits to the comparators
   output reg  [7:0] cold_threshold,
   output reg  [7:0] cool_threshold,
   output reg  [7:0] warm_threshold,
   output reg  [7:0] hot_threshold,
   // Configured reduction fields
   output reg  [2:0] warm_voltage_cut,
   output reg  [2:0] temp_current_scale,
   // Applied charge control
   output reg  [2:0] zone_q,
   output reg  [2:0] vcut_applied_q,
   output reg  [8:0] vcut_mv_q,
   output reg  [3:0] current_eighths_q,
   output reg        charge_hold_q
);

   ////////////////////////////////////////////////////////////////////////////
   // States
   localparam [3:0] ST_IDLE = 4'h0;
   localparam [3:0] ST_ADDR = 4'h1;
   localparam [3:0] ST_AACK = 4'h2;
   localparam [3:0] ST_PTR  = 4'h3;
   localparam [3:0] ST_PACK = 4'h4;
   localparam [3:0] ST_WDAT = 4'h5;
   localparam [3:0] ST_WACK = 4'h6;
   localparam [3:0] ST_RDAT = 4'h7;
   localparam [3:0] ST_RACK = 4'h8;

   ////////////////////////////////////////////////////////////////////////////
   // Functions

   function [8:0] vcut_to_mv;
      input [2:0] code;
      begin
         vcut_to_mv = {6'h00, code} * `TCC_VCUT_STEP_MV;
      end
   endfunction

   function [3:0] scale_to_eighths;
      input [2:0] code;
      begin
         scale_to_eighths = `TCC_ISCALE_FULL - {1'b0, code};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Storage and bus state

   reg  [7:0] reduction_q;
   reg  [7:0] cold_q;
   reg  [7:0] cool_q;
   reg  [7:0] warm_q;
   reg  [7:0] hot_q;

   reg  [3:0] state_q;
   reg  [3:0] state_d;
   reg  [3:0] cnt_q;
   reg  [3:0] cnt_d;
   reg  [7:0] shift_q;
   reg  [7:0] shift_d;
   reg  [7:0] ptr_q;
   reg  [7:0] ptr_d;
   reg  [7:0] rbyte_q;
   reg  [7:0] rbyte_d;
   reg        rw_q;
   reg        rw_d;
   reg        nack_q;
   reg        nack_d;
   reg        oe_d;
   reg        wr_en;
   reg  [7:0] wr_addr;
   reg  [7:0] wr_data;
   reg  [7:0] rd_data;

   wire       scl_rise;
   wire       scl_fall;
   wire       start_det;
   wire       stop_det;
   wire [2:0] zone_w;
   wire [2:0] vcut_w;
   wire [2:0] iscale_w;
   wire       hold_w;

   tcc_bus_edge u_edge (
      .clk       (clk),
      .rst_b     (rst_b),
      .scl       (scl),
      .sda       (sda_in),
      .scl_rise  (scl_rise),
      .scl_fall  (scl_fall),
      .start_det (start_det),
      .stop_det  (stop_det)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Read decode, unmapped offsets read zero

   always @* begin
      case (ptr_q)
         `TCC_OFS_REDUCTION: rd_data = reduction_q;
         `TCC_OFS_COLD:      rd_data = cold_q;
         `TCC_OFS_COOL:      rd_data = cool_q;
         `TCC_OFS_WARM:      rd_data = warm_q;
         `TCC_OFS_HOT:       rd_data = hot_q;
         `TCC_OFS_PART_ID:   rd_data = `TCC_PART_CODE;
         default:            rd_data = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus byte sequencer

   always @* begin
      state_d = state_q;
      cnt_d   = cnt_q;
      shift_d = shift_q;
      ptr_d   = ptr_q;
      rbyte_d = rbyte_q;
      rw_d    = rw_q;
      nack_d  = nack_q;
      oe_d    = sda_oe;
      wr_en   = 1'b0;
      wr_addr = ptr_q;
      wr_data = shift_q;
      if (stop_det) begin
         state_d = ST_IDLE;
         oe_d    = 1'b0;
      end else if (start_det) begin
         state_d = ST_ADDR;
         cnt_d   = 4'h0;
         oe_d    = 1'b0;
      end else if (scl_rise) begin
         case (state_q)
            ST_ADDR, ST_PTR, ST_WDAT: begin
               shift_d = {shift_q[6:0], sda_in};
               cnt_d   = cnt_q + 4'h1;
            end
            ST_RACK: begin
               nack_d = sda_in;
            end
            default: begin
               cnt_d = cnt_q;
            end
         endcase
      end else if (scl_fall) begin
         case (state_q)
            ST_ADDR: begin
               if (cnt_q == `TCC_BYTE_BITS) begin
                  if (shift_q[7:1] == `TCC_BUS_ADDR) begin
                     rw_d    = shift_q[0];
                     oe_d    = 1'b1;
                     state_d = ST_AACK;
                  end else begin
                     state_d = ST_IDLE;
                  end
               end
            end
            ST_AACK: begin
               cnt_d = 4'h0;
               if (rw_q) begin
                  rbyte_d = rd_data;
                  ptr_d   = ptr_q + 8'h01;
                  oe_d    = ~rd_data[7];
                  cnt_d   = 4'h1;
                  state_d = ST_RDAT;
               end else begin
                  oe_d    = 1'b0;
                  state_d = ST_PTR;
               end
            end
            ST_PTR: begin
               if (cnt_q == `TCC_BYTE_BITS) begin
                  ptr_d   = shift_q;
                  oe_d    = 1'b1;
                  state_d = ST_PACK;
               end
            end
            ST_PACK: begin
               oe_d    = 1'b0;
               cnt_d   = 4'h0;
               state_d = ST_WDAT;
            end
            ST_WDAT: begin
               if (cnt_q == `TCC_BYTE_BITS) begin
                  wr_en   = 1'b1;
                  oe_d    = 1'b1;
                  state_d = ST_WACK;
               end
            end
            ST_WACK: begin
               oe_d    = 1'b0;
               cnt_d   = 4'h0;
               ptr_d   = ptr_q + 8'h01;
               state_d = ST_WDAT;
            end
            ST_RDAT: begin
               if (cnt_q == `TCC_BYTE_BITS) begin
                  oe_d    = 1'b0;
                  state_d = ST_RACK;
               end else begin
                  oe_d  = ~rbyte_q[3'h7 - cnt_q[2:0]];
                  cnt_d = cnt_q + 4'h1;
               end
            end
            ST_RACK: begin
               if (nack_q) begin
                  oe_d    = 1'b0;
                  state_d = ST_IDLE;
               end else begin
                  rbyte_d = rd_data;
                  ptr_d   = ptr_q + 8'h01;
                  oe_d    = ~rd_data[7];
                  cnt_d   = 4'h1;
                  state_d = ST_RDAT;
               end
            end
            default: begin
               oe_d = 1'b0;
            end
         endcase
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= ST_IDLE;
         cnt_q   <= 4'h0;
         shift_q <= 8'h00;
         ptr_q   <= 8'h00;
         rbyte_q <= 8'h00;
         rw_q    <= 1'b0;
         nack_q  <= 1'b1;
         sda_oe  <= 1'b0;
         sda_out <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         shift_q <= shift_d;
         ptr_q   <= ptr_d;
         rbyte_q <= rbyte_d;
         rw_q    <= rw_d;
         nack_q  <= nack_d;
         sda_oe  <= oe_d;
         sda_out <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register writes, the part identifier has no storage

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reduction_q <= `TCC_RST_REDUCTION;
         cold_q      <= `TCC_RST_COLD;
         cool_q      <= `TCC_RST_COOL;
         warm_q      <= `TCC_RST_WARM;
         hot_q       <= `TCC_RST_HOT;
      end else if (wr_en) begin
         case (wr_addr)
            `TCC_OFS_REDUCTION: reduction_q <= wr_data;
            `TCC_OFS_COLD:      cold_q      <= wr_data;
            `TCC_OFS_COOL:      cool_q      <= wr_data;
            `TCC_OFS_WARM:      warm_q      <= wr_data;
            `TCC_OFS_HOT:       hot_q       <= wr_data;
            default:            hot_q       <= hot_q;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Zone classification and applied reductions

   tcc_zone u_zone (
      .sense_code         (sense_code),
      .cold_threshold     (cold_q),
      .cool_threshold     (cool_q),
      .warm_threshold     (warm_q),
      .hot_threshold      (hot_q),
      .warm_voltage_cut   (reduction_q[`TCC_VCUT_MSB:`TCC_VCUT_LSB]),
      .temp_current_scale (reduction_q[`TCC_ISCALE_MSB:`TCC_ISCALE_LSB]),
      .zone               (zone_w),
      .vcut_code          (vcut_w),
      .iscale_code        (iscale_w),
      .charge_hold        (hold_w)
   );

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cold_threshold     <= `TCC_RST_COLD;
         cool_threshold     <= `TCC_RST_COOL;
         warm_threshold     <= `TCC_RST_WARM;
         hot_threshold      <= `TCC_RST_HOT;
         warm_voltage_cut   <= 3'h0;
         temp_current_scale <= 3'h0;
         zone_q             <= `TCC_ZONE_NORMAL;
         vcut_applied_q     <= 3'h0;
         vcut_mv_q          <= 9'h000;
         current_eighths_q  <= `TCC_ISCALE_FULL;
         charge_hold_q      <= 1'b0;
      end else begin
         cold_threshold     <= cold_q;
         cool_threshold     <= cool_q;
         warm_threshold     <= warm_q;
         hot_threshold      <= hot_q;
         warm_voltage_cut   <= reduction_q[`TCC_VCUT_MSB:`TCC_VCUT_LSB];
         temp_current_scale <= reduction_q[`TCC_ISCALE_MSB:`TCC_ISCALE_LSB];
         zone_q             <= zone_w;
         vcut_applied_q     <= vcut_w;
         vcut_mv_q          <= vcut_to_mv(vcut_w);
         current_eighths_q  <= scale_to_eighths(iscale_w);
         charge_hold_q      <= hold_w;
      end
   end

endmodule

// File: sim/tcc_regs_assertions.sv
// Concurrent checks on the charge control outputs of the register bank.
// Assumes binding to tcc_regs, one clock and an active low async reset.
`timescale 1ns/100ps
module tcc_regs_chk (
   // Clock and reset
   input wire       clk,
   input wire       rst_b,
   // Sense and limits
   input wire [7:0] sense_code,
   input wire [7:0] cold_threshold,
   input wire [7:0] cool_threshold,
   input wire [7:0] warm_threshold,
   input wire [7:0] hot_threshold,
   // Fields and applied control
   input wire [2:0] warm_voltage_cut,
   input wire [2:0] temp_current_scale,
   input wire [2:0] zone_q,
   input wire [2:0] vcut_applied_q,
   input wire [8:0] vcut_mv_q,
   input wire [3:0] current_eighths_q,
   input wire       charge_hold_q
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   // Cool and warm are the zones that cut current
   wire cut_zone = zone_q == 3'h2 || zone_q == 3'h3;
   // Zone outputs lag the sense code by one edge while the limit outputs lag the limit registers by one edge,
   // so the zone seen now belongs to the previous sense code and the limits shown now
   reg  [7:0] sense_prev;
   reg        live_q;
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sense_prev <= 8'h00;
         live_q     <= 1'b0;
      end else begin
         sense_prev <= sense_code;
         live_q     <= 1'b1;
      end
   end
   ////////////////////////////////////////
   chk_thr_reset: assert property ($rose(rst_b) |->
      cold_threshold == 8'h7c && cool_threshold == 8'h6d && warm_threshold == 8'h38 && hot_threshold == 8'h27)
      else $error("limit outputs not at reset values");
   chk_vcut_scale: assert property (vcut_mv_q == vcut_applied_q * 9'd50)
      else $error("voltage cut not fifty mV per step");
   chk_vcut_warm: assert property (vcut_applied_q != 3'h0 |-> zone_q == 3'h3)
      else $error("voltage cut outside warm zone");
   chk_vcut_field: assert property (zone_q == 3'h3 && $stable(warm_voltage_cut) |->
      vcut_applied_q == warm_voltage_cut)
      else $error("warm voltage cut not the field code");
   chk_cur_cut: assert property (cut_zone && $stable(temp_current_scale) |->
      current_eighths_q == 4'h8 - temp_current_scale)
      else $error("current multiplier not eight minus code");
   chk_cur_full: assert property (!cut_zone |-> current_eighths_q == 4'h8)
      else $error("current cut outside cool and warm");
   chk_hold_zone: assert property (charge_hold_q == (zone_q == 3'h1 || zone_q == 3'h4))
      else $error("charge hold does not follow zone");
   chk_zone_cold: assert property (live_q && sense_prev >= cold_threshold |-> zone_q == 3'h1)
      else $error("cold zone missed");
   chk_zone_hot: assert property (live_q && sense_prev < cold_threshold && sense_prev <= hot_threshold |->
      zone_q == 3'h4)
      else $error("hot zone missed");
   chk_zone_cool: assert property (live_q && sense_prev < cold_threshold && sense_prev > hot_threshold &&
      sense_prev >= cool_threshold |-> zone_q == 3'h2)
      else $error("cool zone missed");
   chk_zone_warm: assert property (live_q && sense_prev < cold_threshold && sense_prev > hot_threshold &&
      sense_prev < cool_threshold && sense_prev <= warm_threshold |-> zone_q == 3'h3)
      else $error("warm zone missed");
   cov_warm_cut: cover property (zone_q == 3'h3 && vcut_applied_q != 3'h0);
   cov_cool_cut: cover property (zone_q == 3'h2 && current_eighths_q != 4'h8);
   cov_cold: cover property (zone_q == 3'h1);
   cov_hot: cover property (zone_q == 3'h4);
endmodule

bind tcc_regs tcc_regs_chk u_tcc_regs_chk (.clk(clk), .rst_b(rst_b), .sense_code(sense_code),
   .cold_threshold(cold_threshold), .cool_threshold(cool_threshold), .warm_threshold(warm_threshold),
   .hot_threshold(hot_threshold), .warm_voltage_cut(warm_voltage_cut), .temp_current_scale(temp_current_scale),
   .zone_q(zone_q), .vcut_applied_q(vcut_applied_q), .vcut_mv_q(vcut_mv_q),
   .current_eighths_q(current_eighths_q), .charge_hold_q(charge_hold_q));

// File: sim/tcc_host.sv
// Two-wire bus host model: drives the clock and pulls the data line.
// Assumes the bench builds the pulled-up data wire.
`timescale 1ns/100ps
module tcc_host (
   // Clock
   input  wire       clk,
   // Data wire level
   input  wire       sda,
   // Lines driven by the host
   output reg        scl,
   output reg        sda_pull,
   // Received byte, strobed for one clock
   output reg  [7:0] rd_byte,
   output reg        rd_stb
);
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
      rd_byte = 8'h00;
      rd_stb = 1'b0;
   end
   // Phase length, above the three clock minimum
   task hw;
      repeat (4) @(negedge clk);
   endtask
   task start;
      begin
         sda_pull = 1'b0;
         hw;
         scl = 1'b1;
         hw;
         sda_pull = 1'b1;
         hw;
         scl = 1'b0;
         hw;
      end
   endtask
   task stop;
      begin
         sda_pull = 1'b1;
         hw;
         scl = 1'b1;
         hw;
         sda_pull = 1'b0;
         hw;
      end
   endtask
   task bit_io(input b, output s);
      begin
         sda_pull = ~b;
         hw;
         scl = 1'b1;
         hw;
         s = sda;
         scl = 1'b0;
         hw;
      end
   endtask
   task xfer(input [7:0] w, output [7:0] r);
      integer n;
      for (n = 7; n >= 0; n = n - 1)
         bit_io(w[n], r[n]);
   endtask
   task send(input [7:0] b, output a);
      reg [7:0] r;
      begin
         xfer(b, r);
         bit_io(1'b1, a);
      end
   endtask
   task recv(input last);
      reg [7:0] r;
      reg       a;
      begin
         xfer(8'hff, r);
         bit_io(last, a);
         rd_byte = r;
         rd_stb = 1'b1;
         @(negedge clk);
         rd_stb = 1'b0;
      end
   endtask
endmodule

// File: sim/tcc_regs_tb.sv
// Self-checking bench for the charge configuration register bank.
// Assumes tcc_regs under hdl/ and the host model and checker under sim/.
`timescale 1ns/100ps
`include "tcc_consts.vh"
module tcc_regs_tb;
   reg         clk;
   reg         rst_b;
   reg  [7:0]  sense_code;
   wire        scl, sda_pull, sda, sda_out, sda_oe, rd_stb, charge_hold_q;
   wire [7:0]  rd_byte, cold_threshold, cool_threshold, warm_threshold, hot_threshold;
   wire [2:0]  warm_voltage_cut, temp_current_scale, zone_q, vcut_applied_q;
   wire [8:0]  vcut_mv_q;
   wire [3:0]  current_eighths_q;
   reg  [7:0]  th [0:3];
   reg  [7:0]  wbuf [0:4];
   reg  [7:0]  exp_q [$];
   reg  [2:0]  vc, ic;
   reg  [31:0] rnd;
   integer     failures, compares, cycles, i, j, k;
   ////////////////////////////////////////
   // Pulled-up wire, low when either side pulls
   assign sda = ~(sda_pull | (sda_oe & ~sda_out));
   tcc_regs u_tcc_regs (.clk(clk), .rst_b(rst_b), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .sense_code(sense_code), .cold_threshold(cold_threshold), .cool_threshold(cool_threshold),
      .warm_threshold(warm_threshold), .hot_threshold(hot_threshold), .warm_voltage_cut(warm_voltage_cut),
      .temp_current_scale(temp_current_scale), .zone_q(zone_q), .vcut_applied_q(vcut_applied_q),
      .vcut_mv_q(vcut_mv_q), .current_eighths_q(current_eighths_q), .charge_hold_q(charge_hold_q));
   tcc_host u_tcc_host (.clk(clk), .sda(sda), .scl(scl), .sda_pull(sda_pull), .rd_byte(rd_byte), .rd_stb(rd_stb));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   function [31:0] lfsr(input [31:0] x);
      lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task check(input [8:0] seen, input [8:0] exp);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task summarize;
      begin
         $display("Comparisons %0d, mismatches %0d", compares, failures);
         if (failures == 0 && compares > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 50000) begin
         failures = failures + 1;
         $display("Error at %0t: run limit reached", $time);
         summarize;
      end
   end
   // Read bytes are compared in arrival order
   always @(posedge clk)
      if (rd_stb === 1'b1)
         check(rd_byte, exp_q.pop_front());
   task snd(input [7:0] b, input a_exp);
      reg a;
      begin
         u_tcc_host.send(b, a);
         check(a, a_exp);
      end
   endtask
   task wr(input [7:0] ofs, input integer n);
      begin
         u_tcc_host.start;
         snd({`TCC_BUS_ADDR, 1'b0}, 1'b0);
         snd(ofs, 1'b0);
         for (i = 0; i < n; i = i + 1)
            snd(wbuf[i], 1'b0);
         u_tcc_host.stop;
      end
   endtask
   task rd(input [7:0] ofs, input integer n);
      begin
         u_tcc_host.start;
         snd({`TCC_BUS_ADDR, 1'b0}, 1'b0);
         snd(ofs, 1'b0);
         u_tcc_host.start;
         snd({`TCC_BUS_ADDR, 1'b1}, 1'b0);
         for (i = 0; i < n; i = i + 1)
            u_tcc_host.recv(i == n - 1);
         u_tcc_host.stop;
         repeat (2) @(negedge clk);
      end
   endtask
   task outs;
      begin
         check(cold_threshold, th[0]);
         check(cool_threshold, th[1]);
         check(warm_threshold, th[2]);
         check(hot_threshold, th[3]);
         check(warm_voltage_cut, vc);
         check(temp_current_scale, ic);
      end
   endtask
   task zchk(input [7:0] s);
      reg [2:0] z;
      begin
         sense_code = s;
         repeat (2) @(negedge clk);
         z = s >= th[0] ? 3'h1 : s <= th[3] ? 3'h4 : s >= th[1] ? 3'h2 : s <= th[2] ? 3'h3 : 3'h0;
         check(zone_q, z);
         check(charge_hold_q, z == 3'h1 || z == 3'h4);
         check(vcut_mv_q, z == 3'h3 ? vc * 9'd50 : 9'h000);
         check(vcut_applied_q, z == 3'h3 ? vc : 3'h0);
         check(current_eighths_q, z == 3'h2 || z == 3'h3 ? 4'h8 - ic : 4'h8);
      end
   endtask
   initial begin
      rst_b = 1'b0;
      sense_code = 8'h50;
      failures = 0;
      compares = 0;
      cycles = 0;
      rnd = 32'd78181;
      th[0] = 8'h7c;
      th[1] = 8'h6d;
      th[2] = 8'h38;
      th[3] = 8'h27;
      vc = 3'h3;
      ic = 3'h4;
      repeat (16) @(negedge clk);
      rst_b = 1'b1;
      repeat (3) @(negedge clk);
      outs;
      exp_q.push_back(8'h34);
      for (k = 0; k < 4; k = k + 1)
         exp_q.push_back(th[k]);
      rd(8'h61, 5);
      $display("Test reset values done");
      // Every reduction code against each zone boundary
      for (k = 0; k < 8; k = k + 1) begin
         vc = k[2:0];
         ic = 3'h7 - k[2:0];
         wbuf[0] = {1'b0, vc, 1'b0, ic};
         wr(8'h61, 1);
         for (j = 0; j < 4; j = j + 1)
            zchk(th[j]);
         zchk(8'h50);
      end
      outs;
      $display("Test reduction codes done");
      // Random limits and reduction in one burst, read back in one burst
      for (k = 0; k < 5; k = k + 1) begin
         rnd = lfsr(rnd);
         wbuf[k] = rnd[7:0];
         exp_q.push_back(rnd[7:0]);
      end
      wr(8'h61, 5);
      rd(8'h61, 5);
      vc = wbuf[0][6:4];
      ic = wbuf[0][2:0];
      for (k = 0; k < 4; k = k + 1)
         th[k] = wbuf[k + 1];
      outs;
      for (k = 0; k < 6; k = k + 1) begin
         rnd = lfsr(rnd);
         zchk(rnd[7:0]);
      end
      $display("Test random limits done");
      // Identifier ignores writes; the next offset is unmapped
      wbuf[0] = 8'hff;
      wr(8'h6f, 1);
      exp_q.push_back(`TCC_PART_CODE);
      exp_q.push_back(8'h00);
      rd(8'h6f, 2);
      u_tcc_host.start;
      snd({`TCC_BUS_ADDR ^ 7'h01, 1'b0}, 1'b1);
      u_tcc_host.stop;
      $display("Test identifier and refusals done");
      summarize;
   end
endmodule
